// File: line_master.sv
`timescale 1ns/10ps
module line_master
   import sensor_pkg::*;
#(
   parameter int SLOT_CYC  = SLOT_SAMPLE_CYC,
   parameter int PRES_WAIT = PRES_WAIT_CYC
)(
   input  wire logic clk,
   input  wire logic dq,
   output logic      pull_low
);
   initial pull_low = 1'b0;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic bus_reset(input int low, output logic seen);
      seen = 1'b0;
      @(posedge clk) pull_low <= 1'b1;
      cyc(low);
      pull_low <= 1'b0;
      repeat (PRES_WAIT + 300)
      begin
         @(posedge clk);
         seen |= !dq;
      end
   endtask : bus_reset
   // A 1 or a read lets go early, a 0 holds past the sample point
   task automatic slot(input logic b, output logic r);
      @(posedge clk) pull_low <= 1'b1;
      cyc(b ? 4 : SLOT_CYC + 10);
      pull_low <= 1'b0;
      cyc(b ? SLOT_CYC / 2 : 1);
      r = dq;
      cyc(b ? SLOT_CYC / 2 + 30 : 30);
   endtask : slot
   task automatic put(input logic [7:0] v);
      logic r;
      for (int i = 0; i < 8; i++)
         slot(v[i], r);
   endtask : put
   task automatic get(output logic [7:0] v);
      for (int i = 0; i < 8; i++)
         slot(1'b1, v[i]);
   endtask : get
   function automatic logic [7:0] crc_run(input logic [7:0] c, input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
      return c;
   endfunction : crc_run
endmodule : line_master

// File: sensor_front.sv
// Notes on behaviour
// - Configuration bits 6:5 pick resolution: 00..11 give 9..12 bits.
// - After power-up both resolution bits are one, full 12-bit resolution.
// - Config bit 7 reads zero, bits 4:0 read ones, writes never change them.
// - Conversion ends within 93.75, 187.5, 375 or 750 ms per resolution.
// - Both check bytes use polynomial x^8 + x^5 + x^4 + 1.
// - Identity check byte covers low 56 bits, stored in top byte.
// - Scratchpad byte 8 is a check over bytes 0..7, always current.
// - A check byte mismatch never halts or refuses a command sequence.
// - All bytes on the line travel least significant bit first.
// - Line driven only by open drain, released when not sending.
// - Any high gap between bits is tolerated; paused master leaves line high.
// - Line low longer than 480 us is a bus reset, abandoning all.
// - Function command only after initialization and identity command, else silent.
// - Each transaction opens with reset pulse; device answers with presence.
// - Device is only ever a slave under one master.
`timescale 1ns/10ps

module byte_fifo
   import sensor_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             push;
   logic             pop;

   assign in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
   assign out_valid = (wr_ptr_r != rd_ptr_r);
   assign out_data  = mem[rd_ptr_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else if (flush)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : byte_fifo

module sensor_front
   import sensor_pkg::*;
#(
   parameter int          RESET_CYC    = RESET_LOW_CYC,
   parameter int          PRES_CYC     = PRES_LOW_CYC,
   parameter int          CONV_CYC     = FULL_CONV_CYC,
   parameter logic [7:0]  FAMILY_CODE  = 8'h5A,        // Arbitrary value
   parameter logic [47:0] SERIAL_NUM   = 48'h0123456789AB, // Arbitrary value
   parameter logic [7:0]  ALARM_HI_DEF = 8'h7F,
   parameter logic [7:0]  ALARM_LO_DEF = 8'h80,
   parameter logic [15:0] TEMP_DEF     = 16'h0000,
   parameter logic [23:0] RSVD_BYTES   = 24'h10_00_FF,
   parameter int          FIFO_DEPTH   = 16,
   parameter int          PRES_WAIT    = PRES_WAIT_CYC,
   parameter int          SLOT_CYC     = SLOT_SAMPLE_CYC
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        dq_in,
   output logic             dq_out,
   output logic             dq_oe,
   input  wire logic [15:0] temp_in,
   output logic             conv_busy,
   output logic [1:0]       res_sel
);
   typedef enum logic [3:0] {
      ST_WAIT_RST  = 4'h0,
      ST_RST_LOW   = 4'h1,
      ST_PRES_WAIT = 4'h2,
      ST_PRES_DRV  = 4'h3,
      ST_ROM_CMD   = 4'h4,
      ST_MATCH     = 4'h5,
      ST_FUNC_CMD  = 4'h6,
      ST_WR_SP     = 4'h7,
      ST_SEND      = 4'h8,
      ST_STATUS    = 4'h9,
      ST_SILENT    = 4'hA
   } state_t;

   localparam logic [55:0] ID_LOW  = {SERIAL_NUM, FAMILY_CODE};
   localparam logic [63:0] ID_CODE = {crc8_calc({8'h00, ID_LOW}, 56), ID_LOW};

   state_t      state_r;
   logic        dq_prev_r;
   logic [31:0] low_cnt_r;
   logic [31:0] tmr_r;
   logic        slot_act_r;
   logic [15:0] slot_cnt_r;
   logic [7:0]  rx_sh_r;
   logic [2:0]  rx_cnt_r;
   logic [7:0]  rx_byte_r;
   logic        rx_vld_r;
   logic [2:0]  tx_idx_r;
   logic [3:0]  cnt_r;
   logic [3:0]  push_len_r;
   logic        push_id_r;
   logic        status_conv_r;
   logic [7:0]  alarm_hi_r;
   logic [7:0]  alarm_lo_r;
   logic [1:0]  res_r;
   logic [15:0] temp_r;
   logic [7:0]  nv_hi_r;
   logic [7:0]  nv_lo_r;
   logic [1:0]  nv_res_r;
   logic [31:0] conv_cnt_r;
   logic        conv_busy_r;
   logic        dq_oe_r;

   logic        bus_rst;
   logic        fall;
   logic        in_link;
   logic        rx_state;
   logic        slot_start;
   logic        slot_evt;
   logic        tx_zero;
   logic [7:0]  cfg_byte;
   logic [63:0] sp_low;
   logic [7:0]  sp_crc;
   logic [7:0]  push_data;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [7:0]  fifo_out_data;
   logic        send_done;

   assign fall       = dq_prev_r && !dq_in;
   assign bus_rst    = (low_cnt_r == 32'(RESET_CYC));
   assign in_link    = (state_r >= ST_ROM_CMD) && (state_r <= ST_STATUS);
   assign rx_state   = (state_r >= ST_ROM_CMD) && (state_r <= ST_WR_SP);
   assign slot_start = fall && !slot_act_r && in_link;
   assign slot_evt   = slot_act_r && (slot_cnt_r == 16'(SLOT_CYC - 1));

   assign cfg_byte = {1'b0, res_r, 5'h00} | CFG_RSVD_VAL;
   assign sp_low   = {RSVD_BYTES, cfg_byte, alarm_lo_r, alarm_hi_r, temp_r};
   assign sp_crc   = crc8_calc(sp_low, 64);

   // Byte to queue: identity code or scratchpad, lowest byte first
   always_comb
   begin
      push_data = 8'h00;
      if (push_id_r)
      begin
         push_data = ID_CODE[{cnt_r[2:0], 3'b000} +: 8];
      end
      else if (cnt_r == SP_CRC_IDX)
      begin
         push_data = sp_crc;
      end
      else
      begin
         push_data = sp_low[{cnt_r[2:0], 3'b000} +: 8];
      end
   end

   assign fifo_in_valid  = (state_r == ST_SEND) && (cnt_r < push_len_r);
   assign fifo_out_ready = (state_r == ST_SEND) && slot_evt && (tx_idx_r == 3'h7);
   assign send_done      = (state_r == ST_SEND) && (cnt_r == push_len_r) && !fifo_out_valid;
   assign tx_zero = ((state_r == ST_SEND) && fifo_out_valid && !fifo_out_data[tx_idx_r])
                    || ((state_r == ST_STATUS) && status_conv_r && conv_busy_r);

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (bus_rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // Line low timer and edge history
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_prev_r <= 1'b1;
         low_cnt_r <= '0;
      end
      else
      begin
         dq_prev_r <= dq_in;
         if (dq_in)
         begin
            low_cnt_r <= '0;
         end
         else if (low_cnt_r <= 32'(RESET_CYC))
         begin
            low_cnt_r <= low_cnt_r + 32'd1;
         end
      end
   end

   // Slot timing: starts at master's falling edge, ends at the sample point or later, once line is high again
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_act_r <= 1'b0;
         slot_cnt_r <= '0;
      end
      else if (bus_rst || slot_start)
      begin
         slot_act_r <= slot_start;
         slot_cnt_r <= '0;
      end
      else if (slot_act_r)
      begin
         if (slot_cnt_r >= 16'(SLOT_CYC - 1) && dq_in)
         begin
            slot_act_r <= 1'b0;
         end
         else if (slot_cnt_r < 16'(SLOT_CYC))
         begin
            slot_cnt_r <= slot_cnt_r + 16'd1;
         end
      end
   end

   // Receive bits into bytes, LSB first
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_sh_r   <= '0;
         rx_cnt_r  <= '0;
         rx_byte_r <= '0;
         rx_vld_r  <= 1'b0;
      end
      else
      begin
         rx_vld_r <= 1'b0;
         if (bus_rst)
         begin
            rx_cnt_r <= '0;
         end
         else if (slot_evt && rx_state)
         begin
            rx_sh_r  <= {dq_in, rx_sh_r[7:1]};
            rx_cnt_r <= rx_cnt_r + 3'd1;
            if (rx_cnt_r == 3'h7)
            begin
               rx_byte_r <= {dq_in, rx_sh_r[7:1]};
               rx_vld_r  <= 1'b1;
            end
         end
      end
   end

   // Transmit bit index within the byte at the queue head
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_idx_r <= '0;
      end
      else if (bus_rst || state_r != ST_SEND)
      begin
         tx_idx_r <= '0;
      end
      else if (slot_evt && fifo_out_valid)
      begin
         tx_idx_r <= tx_idx_r + 3'd1;
      end
   end

   // Open-drain drive: presence pulse and zero bits only, released otherwise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_oe_r <= 1'b0;
      end
      else if (bus_rst)
      begin
         dq_oe_r <= 1'b0;
      end
      else if (state_r == ST_PRES_WAIT && tmr_r == 32'd0)
      begin
         dq_oe_r <= 1'b1;
      end
      else if (state_r == ST_PRES_DRV && tmr_r == 32'd0)
      begin
         dq_oe_r <= 1'b0;
      end
      else if (slot_start && tx_zero)
      begin
         dq_oe_r <= 1'b1;
      end
      else if (slot_evt)
      begin
         dq_oe_r <= 1'b0;
      end
   end

   // Transaction sequencer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r       <= ST_WAIT_RST;
         tmr_r         <= '0;
         cnt_r         <= '0;
         push_len_r    <= '0;
         push_id_r     <= 1'b0;
         status_conv_r <= 1'b0;
      end
      else if (bus_rst)
      begin
         state_r <= ST_RST_LOW;
      end
      else
      begin
         if (tmr_r != 32'd0)
         begin
            tmr_r <= tmr_r - 32'd1;
         end
         if (fifo_in_valid && fifo_in_ready)
         begin
            cnt_r <= cnt_r + 4'd1;
         end
         case (state_r)
            ST_WAIT_RST:
            begin
               state_r <= ST_WAIT_RST;
            end
            ST_RST_LOW:
            begin
               if (dq_in)
               begin
                  state_r <= ST_PRES_WAIT;
                  tmr_r   <= 32'(PRES_WAIT - 1);
               end
            end
            ST_PRES_WAIT:
            begin
               if (tmr_r == 32'd0)
               begin
                  state_r <= ST_PRES_DRV;
                  tmr_r   <= 32'(PRES_CYC - 1);
               end
            end
            ST_PRES_DRV:
            begin
               if (tmr_r == 32'd0)
               begin
                  state_r <= ST_ROM_CMD;
               end
            end
            ST_ROM_CMD:
            begin
               if (rx_vld_r)
               begin
                  cnt_r <= '0;
                  case (rx_byte_r)
                     CMD_READ_ID:
                     begin
                        state_r    <= ST_SEND;
                        push_id_r  <= 1'b1;
                        push_len_r <= ID_LEN;
                     end
                     CMD_MATCH_ID:
                     begin
                        state_r <= ST_MATCH;
                     end
                     CMD_SKIP_ID:
                     begin
                        state_r <= ST_FUNC_CMD;
                     end
                     default:
                     begin
                        state_r <= ST_SILENT;
                     end
                  endcase
               end
            end
            ST_MATCH:
            begin
               if (rx_vld_r)
               begin
                  cnt_r <= cnt_r + 4'd1;
                  if (rx_byte_r != ID_CODE[{cnt_r[2:0], 3'b000} +: 8])
                  begin
                     state_r <= ST_SILENT;
                  end
                  else if (cnt_r == ID_LEN - 4'd1)
                  begin
                     state_r <= ST_FUNC_CMD;
                  end
               end
            end
            ST_FUNC_CMD:
            begin
               if (rx_vld_r)
               begin
                  cnt_r         <= '0;
                  status_conv_r <= 1'b0;
                  case (rx_byte_r)
                     CMD_WRITE_SP:
                     begin
                        state_r <= ST_WR_SP;
                     end
                     CMD_READ_SP:
                     begin
                        state_r    <= ST_SEND;
                        push_id_r  <= 1'b0;
                        push_len_r <= SP_LEN;
                     end
                     CMD_CONVERT:
                     begin
                        state_r       <= ST_STATUS;
                        status_conv_r <= 1'b1;
                     end
                     CMD_COPY_SP, CMD_RECALL, CMD_READ_POWER:
                     begin
                        state_r <= ST_STATUS;
                     end
                     default:
                     begin
                        state_r <= ST_SILENT;
                     end
                  endcase
               end
            end
            ST_WR_SP:
            begin
               if (rx_vld_r)
               begin
                  cnt_r <= cnt_r + 4'd1;
                  if (cnt_r == WR_SP_LEN - 4'd1)
                  begin
                     state_r <= ST_SILENT;
                  end
               end
            end
            ST_SEND:
            begin
               if (send_done)
               begin
                  state_r <= push_id_r ? ST_FUNC_CMD : ST_SILENT;
               end
            end
            ST_STATUS, ST_SILENT:
            begin
               state_r <= state_r;
            end
            default:
            begin
               state_r <= ST_WAIT_RST;
            end
         endcase
      end
   end

   // Scratchpad writable bytes and their nonvolatile copies
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_hi_r <= ALARM_HI_DEF;
         alarm_lo_r <= ALARM_LO_DEF;
         res_r      <= RES_RESET;
         nv_hi_r    <= ALARM_HI_DEF;
         nv_lo_r    <= ALARM_LO_DEF;
         nv_res_r   <= RES_RESET;
      end
      else if (state_r == ST_WR_SP && rx_vld_r)
      begin
         case (cnt_r)
            SP_ALARM_HI_IDX - 4'd2: alarm_hi_r <= rx_byte_r;
            SP_ALARM_LO_IDX - 4'd2: alarm_lo_r <= rx_byte_r;
            SP_CFG_IDX - 4'd2:      res_r      <= rx_byte_r[RES_LSB +: 2];
            default:                res_r      <= res_r;
         endcase
      end
      else if (state_r == ST_FUNC_CMD && rx_vld_r && rx_byte_r == CMD_COPY_SP)
      begin
         nv_hi_r  <= alarm_hi_r;
         nv_lo_r  <= alarm_lo_r;
         nv_res_r <= res_r;
      end
      else if (state_r == ST_FUNC_CMD && rx_vld_r && rx_byte_r == CMD_RECALL)
      begin
         alarm_hi_r <= nv_hi_r;
         alarm_lo_r <= nv_lo_r;
         res_r      <= nv_res_r;
      end
   end

   // Conversion timer; length halves for each resolution bit dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_cnt_r  <= '0;
         conv_busy_r <= 1'b0;
         temp_r      <= TEMP_DEF;
      end
      else if (state_r == ST_FUNC_CMD && rx_vld_r && rx_byte_r == CMD_CONVERT && !conv_busy_r)
      begin
         conv_cnt_r  <= 32'(CONV_CYC) >> (2'd3 - res_r);
         conv_busy_r <= 1'b1;
      end
      else if (conv_busy_r)
      begin
         conv_cnt_r <= conv_cnt_r - 32'd1;
         if (conv_cnt_r <= 32'd1)
         begin
            conv_busy_r <= 1'b0;
            temp_r      <= temp_in;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_out    <= 1'b0;
         dq_oe     <= 1'b0;
         conv_busy <= 1'b0;
         res_sel   <= RES_RESET;
      end
      else
      begin
         dq_out    <= 1'b0;
         dq_oe     <= dq_oe_r;
         conv_busy <= conv_busy_r;
         res_sel   <= res_r;
      end
   end

endmodule : sensor_front

// File: sensor_front_checker.sv
`timescale 1ns/10ps
module sensor_front_checker
   import sensor_pkg::*;
#(
   parameter int RESET_CYC = 4000,
   parameter int PRES_CYC  = 40,
   parameter int CONV_CYC  = 8000,
   parameter int PRES_WAIT = PRES_WAIT_CYC,
   parameter int SLOT_CYC  = SLOT_SAMPLE_CYC
)(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        dq_in,
   input wire logic        dq_out,
   input wire logic        dq_oe,
   input wire logic [15:0] temp_in,
   input wire logic        conv_busy,
   input wire logic [1:0]  res_sel
);
   int   low_r;
   int   hi_r;
   int   oe_r;
   int   busy_r;
   logic arm_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Run lengths on the line; arm marks a bus reset still owed a presence
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         low_r <= 0;
         hi_r  <= 0;
         oe_r  <= 0;
         arm_r <= 1'b0;
      end
      else
      begin
         low_r <= dq_in ? 0 : low_r + 1;
         hi_r  <= dq_in ? hi_r + 1 : 0;
         oe_r  <= dq_oe ? oe_r + 1 : 0;
         arm_r <= (low_r > RESET_CYC) || (arm_r && !dq_oe);
      end
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         busy_r <= 0;
      else
         busy_r <= conv_busy ? busy_r + 1 : 0;
   a_out_low: assert property (!dq_out)
      else $error("data pin driven high");
   a_reset_full: assert property ($rose(rst_n) |-> res_sel == 2'h3 && !conv_busy)
      else $error("bad state after reset");
   a_presence_wait: assert property (arm_r && dq_oe |-> hi_r >= PRES_WAIT)
      else $error("presence too early");
   a_presence_due: assert property (arm_r |-> hi_r <= PRES_WAIT + 8)
      else $error("presence missing");
   a_drive_len: assert property ($fell(dq_oe) |-> oe_r >= PRES_CYC
      && oe_r <= SLOT_CYC + 4)
      else $error("drive length wrong");
   a_drive_stands: assert property ($rose(dq_oe) |-> dq_oe [*8])
      else $error("drive dropped early");
   a_reset_quiet: assert property (low_r > RESET_CYC + 2 |-> !dq_oe)
      else $error("drive during bus reset");
   a_conv_time: assert property ($fell(conv_busy) |->
      busy_r <= (CONV_CYC >> (3 - res_sel)) + 1
      && busy_r > (CONV_CYC >> (4 - res_sel)))
      else $error("conversion length wrong");
   c_presence: cover property (arm_r && $rose(dq_oe));
   c_read_zero: cover property (!arm_r && $rose(dq_oe));
   c_conv_done: cover property ($fell(conv_busy));
endmodule : sensor_front_checker

bind sensor_front sensor_front_checker #(
   .RESET_CYC(RESET_CYC), .PRES_CYC(PRES_CYC), .CONV_CYC(CONV_CYC),
   .PRES_WAIT(PRES_WAIT), .SLOT_CYC(SLOT_CYC)
) watch (
   .clk(clk), .rst_n(rst_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
   .temp_in(temp_in), .conv_busy(conv_busy), .res_sel(res_sel)
);

// File: sensor_front_test.sv
`timescale 1ns/10ps
module sensor_front_test
   import sensor_pkg::*;
();
   localparam int          RST_CYC = 200;
   localparam int          SLOT    = 100;
   localparam int          PWAIT   = 100;
   localparam logic [7:0]  FAM     = 8'h5A;   // Arbitrary value
   localparam logic [15:0] TEMP    = 16'h0191;
   typedef struct packed { logic [7:0] cfg; logic [1:0] res; } row_t;
   row_t        rows [4] = '{'{8'h80, 2'h0}, '{8'hE0, 2'h3}, '{8'hA0, 2'h1}, '{8'hC0, 2'h2}};
   logic        clk;
   logic        rst_n;
   logic [15:0] temp_in;
   logic        dq_out;
   logic        dq_oe;
   logic        conv_busy;
   logic [1:0]  res_sel;
   logic        m_low;
   wire         dq = !((dq_oe && !dq_out) || m_low);
   int          n_errors = 0;
   int          checks = 0;
   int          k;
   logic [7:0]  b [9];
   logic [7:0]  c;
   logic        p;
   always #5 clk = ~clk;
   sensor_front #(.RESET_CYC(RST_CYC), .PRES_CYC(40), .CONV_CYC(8000), .FAMILY_CODE(FAM),
      .PRES_WAIT(PWAIT), .SLOT_CYC(SLOT)) dut (
      .clk(clk), .rst_n(rst_n), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe),
      .temp_in(temp_in), .conv_busy(conv_busy), .res_sel(res_sel));
   line_master #(.SLOT_CYC(SLOT), .PRES_WAIT(PWAIT)) m (.clk(clk), .dq(dq), .pull_low(m_low));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic start();
      m.bus_reset(RST_CYC + 50, p);
      chk({7'h0, p}, 8'h01);
   endtask : start
   task automatic crc_chk(input int n);
      c = 8'h00;
      for (int i = 0; i < n; i++)
         c = m.crc_run(c, b[i]);
      chk(c, 8'h00);
   endtask : crc_chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      temp_in = 16'h0000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      temp_in <= TEMP;
      @(posedge clk);
      chk({6'h0, res_sel}, 8'h03);
      foreach (rows[i])
      begin
         start();
         m.put(8'hCC);
         m.put(8'h4E);
         m.put(8'h12);
         m.put(8'h34);
         m.put(rows[i].cfg);
         chk({6'h0, res_sel}, {6'h0, rows[i].res});
      end
      $display("test resolution rows finished");
      start();
      m.put(8'hCC);
      m.put(8'h44);
      m.slot(1'b1, p);
      chk({7'h0, p}, 8'h00);
      k = 0;
      while (conv_busy !== 1'b0 && k < 10000)
      begin
         @(posedge clk);
         k++;
      end
      chk({7'h0, conv_busy}, 8'h00);
      if (k >= 10000)
         end_of_test();
      temp_in <= 16'h0550;
      m.slot(1'b1, p);
      chk({7'h0, p}, 8'h01);
      $display("test conversion finished");
      start();
      m.put(8'hCC);
      m.put(8'hBE);
      for (int i = 0; i < 9; i++)
         m.get(b[i]);
      chk(b[0], TEMP[7:0]);
      chk(b[1], TEMP[15:8]);
      chk(b[2], 8'h12);
      chk(b[3], 8'h34);
      chk(b[4], 8'h5F);
      crc_chk(9);
      $display("test scratchpad read finished");
      start();
      m.put(8'h33);
      for (int i = 0; i < 8; i++)
         m.get(b[i]);
      chk(b[0], FAM);
      crc_chk(8);
      m.put(8'hBE);
      m.get(c);
      chk(c, TEMP[7:0]);
      start();
      m.put(8'h55);
      for (int i = 0; i < 8; i++)
         m.put(b[i]);
      m.put(8'hBE);
      m.get(c);
      chk(c, TEMP[7:0]);
      $display("test identity read finished");
      start();
      m.put(8'hBE);
      m.get(c);
      chk(c, 8'hFF);
      start();
      m.put(8'hF0);
      m.get(c);
      chk(c, 8'hFF);
      $display("test silence finished");
      start();
      m.put(8'hCC);
      for (int i = 0; i < 4; i++)
         m.slot(1'b0, p);
      start();
      m.put(8'hCC);
      m.cyc(2000);
      m.put(8'hBE);
      m.get(c);
      chk(c, TEMP[7:0]);
      $display("test bus reset finished");
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({6'h0, res_sel}, 8'h03);
      chk({7'h0, conv_busy}, 8'h00);
      rst_n <= 1'b1;
      start();
      chk({6'h0, res_sel}, 8'h03);
      $display("test power reset finished");
      end_of_test();
   end
endmodule : sensor_front_test

// File: sensor_pkg.sv
package sensor_pkg;

   localparam int CLK_MHZ = 100;

   // Line timing, figures in microseconds, counts in clock cycles
   localparam int RESET_LOW_US   = 480;
   localparam int PRES_WAIT_US   = 30;
   localparam int PRES_LOW_US    = 120;
   localparam int SLOT_SAMPLE_US = 30;
   localparam int RESET_LOW_CYC   = RESET_LOW_US * CLK_MHZ;
   localparam int PRES_WAIT_CYC   = PRES_WAIT_US * CLK_MHZ;
   localparam int PRES_LOW_CYC    = PRES_LOW_US * CLK_MHZ;
   localparam int SLOT_SAMPLE_CYC = SLOT_SAMPLE_US * CLK_MHZ;

   // Longest conversion, full resolution; lower resolutions halve it per bit
   localparam int FULL_CONV_TIME_US = 750000;
   localparam int FULL_CONV_CYC     = FULL_CONV_TIME_US * CLK_MHZ;

   // Scratchpad layout
   localparam logic [3:0] SP_TEMP_LSB_IDX = 4'h0;
   localparam logic [3:0] SP_TEMP_MSB_IDX = 4'h1;
   localparam logic [3:0] SP_ALARM_HI_IDX = 4'h2;
   localparam logic [3:0] SP_ALARM_LO_IDX = 4'h3;
   localparam logic [3:0] SP_CFG_IDX      = 4'h4;
   localparam logic [3:0] SP_CRC_IDX      = 4'h8;
   localparam logic [3:0] SP_LEN          = 4'h9;
   localparam logic [3:0] ID_LEN          = 4'h8;
   localparam logic [3:0] WR_SP_LEN       = 4'h3;

   // resolution_config fields
   localparam int         RES_LSB      = 5;
   localparam logic [1:0] RES_RESET    = 2'h3;
   localparam logic [7:0] CFG_RSVD_VAL = 8'h1F;

   localparam logic [7:0] CRC_TAPS_LSB_FIRST = 8'h8C;

   typedef enum logic [7:0] {
      CMD_READ_ID      = 8'h33,
      CMD_MATCH_ID     = 8'h55,
      CMD_SKIP_ID      = 8'hCC,
      CMD_SEARCH       = 8'hF0,
      CMD_ALARM_SEARCH = 8'hEC,
      CMD_CONVERT      = 8'h44,
      CMD_WRITE_SP     = 8'h4E,
      CMD_READ_SP      = 8'hBE,
      CMD_COPY_SP      = 8'h48,
      CMD_RECALL       = 8'hB8,
      CMD_READ_POWER   = 8'hB4
   } cmd_t;

   // Check byte over the low nbits of d, cleared start, fed LSB first
   function automatic logic [7:0] crc8_calc(input logic [63:0] d, input int nbits);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (i < nbits) begin
            fb = c[0] ^ d[i];
            c  = {1'b0, c[7:1]} ^ (fb ? CRC_TAPS_LSB_FIRST : 8'h00);
         end
      end
      return c;
   endfunction : crc8_calc

endpackage : sensor_pkg
